/* design/wiper_command_unit.sv */
// Command core of the two-channel wiper controller
module wiper_command_unit (
    input wire logic mclk,                 // 40 MHz system clock
    input wire logic resetn,               // Async reset, active low
    input wire logic sclkPin,              // Host serial clock
    input wire logic csPin_n,              // Chip select, active low
    input wire logic sdiPin,               // Serial data in
    output logic sdoOut,                   // Serial out level (always 0)
    output logic sdoOe,                    // Serial out pull-down enable
    input wire logic preset_strobe_n,      // Preset, active low
    input wire logic writeProtect_n,       // Write protect, active low
    output logic readyOut,                 // Ready level (always 0)
    output logic readyOe,                  // Ready pull-down enable
    output logic [wiper_cmd_pkg::WIPER_BITS-1:0] wiperOne,  // Channel 0 setting
    output logic [wiper_cmd_pkg::WIPER_BITS-1:0] wiperTwo   // Channel 1 setting
);
    import wiper_cmd_pkg::*;
    parameter int STORE_WAIT = STORE_CYCLES;   // Store time in cycles

    typedef enum {ST_BOOT, ST_IDLE, ST_STORE, ST_READY} core_e;

    serial_link_if link ();
    logic [9:0] wiper_reg [2];             // wiper_setting_reg per channel
    logic [9:0] wiper_next [2];
    // Store words start at midscale and resetn never touches them;
    // only the writer process below changes a word
    logic [15:0] nonvolatile_store [STORE_DEPTH] = '{default: {6'h00, WIPER_MID}};
    logic [15:0] nvWrData;                 // Word to write
    logic [3:0] nvWrAddr;                  // Where to write
    logic nvWr;                            // Write strobe
    core_e st_reg, st_next;                // Core state
    logic [19:0] tmr_reg, tmr_next;        // Store/ready timer
    logic [23:0] last_reg, last_next;      // Last executed frame
    logic lastOk_reg, lastOk_next;         // A frame has run
    logic [1:0] pr_reg, pr_next;           // Preset synchroniser
    logic prOld_reg, prOld_next;           // Preset previous
    logic [1:0] wp_reg, wp_next;           // Protect synchroniser
    logic [23:0] reply;                    // Readback word
    logic replyLoad;                       // Readback strobe
    logic [23:0] word;                     // Frame being executed
    logic [3:0] commandField;              // Command code
    logic [3:0] addressField;              // Address code
    logic [15:0] dataField;                // Data bits
    logic ch;                              // channel_select_bit
    logic pendReady;                       // Ready after this command
    logic prRise;

    serial_shifter shifter (
        .mclk(mclk),
        .resetn(resetn),
        .sclkPin(sclkPin),
        .csPin_n(csPin_n),
        .sdiPin(sdiPin),
        .sdoOut(sdoOut),
        .sdoOe(sdoOe),
        .link(link)
    );

    // Saturating step and doubling helpers
    function automatic logic [9:0] stepUp(input logic [9:0] v);
        stepUp = (v == WIPER_FULL) ? v : v + 10'h001;
    endfunction : stepUp
    function automatic logic [9:0] stepDown(input logic [9:0] v);
        stepDown = (v == 10'h000) ? v : v - 10'h001;
    endfunction : stepDown
    function automatic logic [9:0] dbl(input logic [9:0] v);
        dbl = v[9] ? WIPER_FULL : {v[8:0], 1'b0};
    endfunction : dbl

    // Command decode and wiper update
    always_comb begin
        pr_next = {pr_reg[0], preset_strobe_n};
        wp_next = {wp_reg[0], writeProtect_n};
        prOld_next = pr_reg[1];
        prRise = pr_reg[1] & ~prOld_reg;
        // Bare select pulse repeats the previous command
        word = (link.bitsSeen || !lastOk_reg) ? link.frameWord : last_reg;
        commandField = word[CMD_MSB:CMD_LSB];
        addressField = word[ADDR_MSB:ADDR_LSB];
        dataField = word[DATA_BITS-1:0];
        ch = addressField[0];
        wiper_next = wiper_reg;
        st_next = st_reg;
        tmr_next = tmr_reg;
        last_next = last_reg;
        lastOk_next = lastOk_reg;
        nvWr = 1'b0;
        nvWrAddr = addressField;
        nvWrData = dataField;
        reply = FRAME_ZERO;
        replyLoad = 1'b0;
        pendReady = 1'b0;
        case (st_reg)
            ST_BOOT: begin
                // Power-on load from store
                wiper_next[0] = nonvolatile_store[0][9:0];
                wiper_next[1] = nonvolatile_store[1][9:0];
                st_next = ST_IDLE;
            end
            ST_IDLE: begin
                if (!pr_reg[1]) begin
                    wiper_next[0] = WIPER_MID; // Preset low gives midscale
                    wiper_next[1] = WIPER_MID;
                end else if (prRise) begin
                    wiper_next[0] = nonvolatile_store[0][9:0];
                    wiper_next[1] = nonvolatile_store[1][9:0];
                    pendReady = 1'b1;
                end else if (link.frameDone) begin
                    last_next = word;
                    lastOk_next = 1'b1;
                    case (commandField)
                        CMD_NOP: begin
                            pendReady = 1'b0;  // Nothing to do
                        end
                        CMD_RELOAD: begin
                            wiper_next[ch] = nonvolatile_store[{3'h0, ch}][9:0];
                        end
                        CMD_RELOAD_ALL: begin
                            wiper_next[0] = nonvolatile_store[0][9:0];
                            wiper_next[1] = nonvolatile_store[1][9:0];
                            pendReady = 1'b1;
                        end
                        CMD_STORE_W: begin
                            nvWr = 1'b1;
                            nvWrAddr = {3'h0, ch};
                            nvWrData = {6'h00, wiper_reg[ch]};
                            st_next = ST_STORE;
                            tmr_next = 20'(STORE_WAIT);
                        end
                        CMD_STORE_D: begin
                            if (addressField != ADDR_RESERVED) begin
                                nvWr = 1'b1;
                                st_next = ST_STORE;
                                tmr_next = 20'(STORE_WAIT);
                            end
                        end
                        CMD_READ_NV: begin
                            reply = {word[23:16], nonvolatile_store[addressField]};
                            replyLoad = 1'b1;
                            pendReady = 1'b1;
                        end
                        CMD_READ_W: begin
                            reply = {word[23:16], 6'h00, wiper_reg[ch]};
                            replyLoad = 1'b1;
                            pendReady = 1'b1;
                        end
                        default: begin
                            if (wp_reg[1]) begin   // Protect blocks write and step commands
                                case (commandField)
                                    CMD_WRITE_W: wiper_next[ch] = dataField[9:0];
                                    CMD_HALF: wiper_next[ch] = wiper_reg[ch] >> 1;
                                    CMD_DBL: wiper_next[ch] = dbl(wiper_reg[ch]);
                                    CMD_DEC: wiper_next[ch] = stepDown(wiper_reg[ch]);
                                    CMD_INC: wiper_next[ch] = stepUp(wiper_reg[ch]);
                                    default: begin
                                        for (int i = 0; i < 2; i++) begin
                                            case (commandField)
                                                CMD_HALF_ALL: wiper_next[i] = wiper_reg[i] >> 1;
                                                CMD_DBL_ALL: wiper_next[i] = dbl(wiper_reg[i]);
                                                CMD_DEC_ALL: wiper_next[i] = stepDown(wiper_reg[i]);
                                                CMD_INC_ALL: wiper_next[i] = stepUp(wiper_reg[i]);
                                                default: wiper_next[i] = wiper_reg[i];
                                            endcase
                                        end
                                    end
                                endcase
                            end
                        end
                    endcase
                end
                if (pendReady) begin
                    st_next = ST_READY;
                    tmr_next = 20'(READY_PULSE_CYCLES);
                end
            end
            ST_STORE: begin
                // Shifter locked meanwhile
                tmr_next = tmr_reg - 20'h0_0001;
                if (tmr_reg == 20'h0_0001) begin
                    st_next = ST_READY;
                    tmr_next = 20'(READY_PULSE_CYCLES);
                end
            end
            ST_READY: begin
                tmr_next = tmr_reg - 20'h0_0001;
                if (tmr_reg == 20'h0_0001) begin
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wiper_reg[0] <= WIPER_MID;
            wiper_reg[1] <= WIPER_MID;
            st_reg <= ST_BOOT;
            tmr_reg <= 20'h0_0000;
            last_reg <= FRAME_ZERO;
            lastOk_reg <= 1'b0;
            pr_reg <= 2'h3;
            prOld_reg <= 1'b1;
            wp_reg <= 2'h3;
        end else begin
            wiper_reg <= wiper_next;
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            last_reg <= last_next;
            lastOk_reg <= lastOk_next;
            pr_reg <= pr_next;
            prOld_reg <= prOld_next;
            wp_reg <= wp_next;
        end
    end

    // Nonvolatile array writer, the one process that drives the array,
    // so stored words and the midscale default survive resetn
    always_ff @(posedge mclk) begin
        if (nvWr) begin
            nonvolatile_store[nvWrAddr] <= nvWrData;
        end
    end

    assign link.replyWord = reply;
    assign link.replyLoad = replyLoad;
    assign link.locked = (st_reg == ST_STORE);
    assign readyOut = 1'b0;
    assign readyOe = (st_reg == ST_READY);         // Low pulse when done
    assign wiperOne = wiper_reg[0];
    assign wiperTwo = wiper_reg[1];
endmodule : wiper_command_unit

/* common/wiper_cmd_pkg.sv */
package wiper_cmd_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int WIPER_BITS = 10;
    localparam int DATA_BITS = 16;
    localparam int STORE_DEPTH = 16;
    localparam logic [3:0] ADDR_RESERVED = 4'h000F;
    localparam logic [9:0] WIPER_MID = 10'h0200;
    localparam logic [9:0] WIPER_FULL = 10'h03FF;
    localparam logic [3:0] CMD_NOP = 4'h0000;
    localparam logic [3:0] CMD_RELOAD = 4'h0001;
    localparam logic [3:0] CMD_STORE_W = 4'h0002;
    localparam logic [3:0] CMD_STORE_D = 4'h0003;
    localparam logic [3:0] CMD_HALF = 4'h0004;
    localparam logic [3:0] CMD_HALF_ALL = 4'h0005;
    localparam logic [3:0] CMD_DEC = 4'h0006;
    localparam logic [3:0] CMD_DEC_ALL = 4'h0007;
    localparam logic [3:0] CMD_RELOAD_ALL = 4'h0008;
    localparam logic [3:0] CMD_READ_NV = 4'h0009;
    localparam logic [3:0] CMD_READ_W = 4'h000A;
    localparam logic [3:0] CMD_WRITE_W = 4'h000B;
    localparam logic [3:0] CMD_DBL = 4'h000C;
    localparam logic [3:0] CMD_DBL_ALL = 4'h000D;
    localparam logic [3:0] CMD_INC = 4'h000E;
    localparam logic [3:0] CMD_INC_ALL = 4'h000F;
    localparam int CLK_HZ = 40_000_000;
    localparam int STORE_MS = 15;
    localparam int STORE_CYCLES = (CLK_HZ / 1000) * STORE_MS;
    localparam int READY_PULSE_CYCLES = 4;
    localparam logic [23:0] FRAME_ZERO = 24'h00_0000;
endpackage : wiper_cmd_pkg

/* common/serial_link_if.sv */
// Frames and status passing between shifter and command core
interface serial_link_if;
    import wiper_cmd_pkg::*;
    logic frameDone;            // One-cycle pulse on select rise
    logic [23:0] frameWord;     // Last 24 bits shifted in
    logic bitsSeen;             // Any rising clock edge during frame
    logic [23:0] replyWord;     // Word to shift out next frame
    logic replyLoad;            // Pulse: replace echo word
    logic locked;               // Store in progress
    modport shifter (output frameDone, output frameWord, output bitsSeen,
                     input replyWord, input replyLoad, input locked);
    modport core (input frameDone, input frameWord, input bitsSeen,
                  output replyWord, output replyLoad, output locked);
endinterface : serial_link_if

/* design/serial_shifter.sv */
// Samples the host pins and assembles frames
module serial_shifter (
    input wire logic mclk,                 // System clock
    input wire logic resetn,               // Async reset, active low
    input wire logic sclkPin,              // Host serial clock
    input wire logic csPin_n,              // Host chip select
    input wire logic sdiPin,               // Host serial data
    output logic sdoOut,                   // Serial output level
    output logic sdoOe,                    // Pull low when high
    serial_link_if.shifter link            // To command core
);
    import wiper_cmd_pkg::*;
    logic [2:0] s1_reg, s1_next;           // First sync stage
    logic [2:0] s2_reg, s2_next;           // Second sync stage
    logic [2:0] s3_reg, s3_next;           // Delayed for edges
    logic [23:0] shIn_reg, shIn_next;      // Incoming bits
    logic [23:0] shOut_reg, shOut_next;    // Outgoing bits
    logic [23:0] prev_reg, prev_next;      // Last frame for echo
    logic [4:0] cnt_reg, cnt_next;         // Bit count mod 24
    logic [5:0] tot_reg, tot_next;         // Bits this select
    logic done_reg, done_next;             // Frame pulse
    logic seen_reg, seen_next;             // Activity flag
    logic sdo_reg, sdo_next;               // Output bit
    logic sclkRise, sclkFall, csRise, csFall, csLow;

    // Edge detection on synchronised pins
    always_comb begin
        s1_next = {sclkPin, csPin_n, sdiPin};
        s2_next = s1_reg;
        s3_next = s2_reg;
        sclkRise = s2_reg[2] & ~s3_reg[2];
        sclkFall = ~s2_reg[2] & s3_reg[2];
        csRise = s2_reg[1] & ~s3_reg[1];
        csFall = ~s2_reg[1] & s3_reg[1];
        csLow = ~s2_reg[1];
    end

    // Shift in on rising clock, out on falling: modes 0,0 and 1,1
    always_comb begin
        shIn_next = shIn_reg;
        shOut_next = shOut_reg;
        prev_next = prev_reg;
        cnt_next = cnt_reg;
        tot_next = tot_reg;
        done_next = 1'b0;
        seen_next = seen_reg;
        sdo_next = sdo_reg;
        if (link.replyLoad) begin
            prev_next = link.replyWord;        // Readback overrides echo
        end
        if (csFall) begin
            shOut_next = prev_reg;             // Echo previous frame
            sdo_next = prev_reg[23];
            seen_next = 1'b0;
            tot_next = 6'h00;
        end else if (csLow && sclkRise && !link.locked) begin
            shIn_next = {shIn_reg[22:0], s2_reg[0]}; // MSB first
            seen_next = 1'b1;
            tot_next = tot_reg + 6'h01;
            cnt_next = (cnt_reg == 5'(FRAME_BITS - 1)) ? 5'h00 : cnt_reg + 5'h01;
        end else if (csLow && sclkFall && !link.locked) begin
            shOut_next = {shOut_reg[22:0], 1'b0};
            sdo_next = shOut_reg[22];
        end else if (csRise) begin
            done_next = 1'b1;                  // Execute on rise
            if (tot_reg[1:0] != 2'b00) begin
                cnt_next = 5'h00;              // Drop misaligned count
            end else if (seen_reg) begin
                prev_next = shIn_reg;
            end
        end
    end

    // Register stage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= 3'h7;
            s2_reg <= 3'h7;
            s3_reg <= 3'h7;
            shIn_reg <= FRAME_ZERO;
            shOut_reg <= FRAME_ZERO;
            prev_reg <= FRAME_ZERO;
            cnt_reg <= 5'h00;
            tot_reg <= 6'h00;
            done_reg <= 1'b0;
            seen_reg <= 1'b0;
            sdo_reg <= 1'b1;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            shIn_reg <= shIn_next;
            shOut_reg <= shOut_next;
            prev_reg <= prev_next;
            cnt_reg <= cnt_next;
            tot_reg <= tot_next;
            done_reg <= done_next;
            seen_reg <= seen_next;
            sdo_reg <= sdo_next;
        end
    end

    assign link.frameDone = done_reg;
    assign link.frameWord = shIn_reg;
    assign link.bitsSeen = seen_reg;
    assign sdoOut = 1'b0;
    assign sdoOe = ~s2_reg[1] & ~sdo_reg;      // Released while select high
endmodule : serial_shifter

/* verif/wiper_command_unit_asserts.sv */
// Protocol checker beside the wiper command core
module wiper_command_unit_asserts #(
    parameter int STORE_WAIT = wiper_cmd_pkg::STORE_CYCLES  // Store time in cycles
) (
    input wire logic mclk,                 // System clock
    input wire logic resetn,               // Async reset, active low
    input wire logic sclkPin,              // Host serial clock
    input wire logic csPin_n,              // Chip select
    input wire logic sdiPin,               // Serial data in
    input wire logic sdoOut,               // Serial out level
    input wire logic sdoOe,                // Serial out pull enable
    input wire logic preset_strobe_n,      // Preset strobe
    input wire logic writeProtect_n,       // Write protect
    input wire logic readyOut,             // Ready level
    input wire logic readyOe,              // Ready pull enable
    input wire logic [wiper_cmd_pkg::WIPER_BITS-1:0] wiperOne,  // Channel 0
    input wire logic [wiper_cmd_pkg::WIPER_BITS-1:0] wiperTwo   // Channel 1
);
    import wiper_cmd_pkg::*;
    // One domain: shared clock and reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_sdo_released: assert property (csPin_n [*5] |-> !sdoOe)
        else $error("serial output driven while deselected");
    a_ready_pulse_len: assert property ($rose(readyOe) |-> readyOe [*4] ##1 !readyOe)
        else $error("ready pulse length wrong");
    a_ready_low_level: assert property (readyOe |-> readyOut == 1'b0)
        else $error("ready pin level not low");
    a_sdo_low_level: assert property (sdoOe |-> sdoOut == 1'b0)
        else $error("serial out level not low");
    a_wiper_quiet_frame: assert property ((!csPin_n && preset_strobe_n) [*8]
        |-> $stable(wiperOne) && $stable(wiperTwo))
        else $error("wiper moved in mid-frame");
    a_preset_mid: assert property (!preset_strobe_n [*6]
        |-> wiperOne == WIPER_MID && wiperTwo == WIPER_MID)
        else $error("preset low without midscale");
    a_preset_ready: assert property ($rose(preset_strobe_n) |-> ##[1:12] readyOe)
        else $error("no ready after preset release");
    a_boot_mid: assert property ($rose(resetn) |-> $past(wiperOne) == WIPER_MID)
        else $error("wiper not midscale in reset");
    // Main scenarios reached
    c_ready: cover property ($rose(readyOe));
    c_frame: cover property ($rose(csPin_n));
    c_preset: cover property ($fell(preset_strobe_n));
endmodule : wiper_command_unit_asserts

bind wiper_command_unit wiper_command_unit_asserts #(.STORE_WAIT(STORE_WAIT)) i_chk (
    .mclk(mclk), .resetn(resetn), .sclkPin(sclkPin), .csPin_n(csPin_n), .sdiPin(sdiPin),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .preset_strobe_n(preset_strobe_n),
    .writeProtect_n(writeProtect_n), .readyOut(readyOut), .readyOe(readyOe),
    .wiperOne(wiperOne), .wiperTwo(wiperTwo)
);

/* verif/spi_host_model.sv */
// Serial host in clock mode 0,0 with a 200 ns bit period
module spi_host_model (
    input wire logic mclk,     // System clock paces the host
    output logic sclkPin,      // Serial clock, idle low
    output logic csPin_n,      // Chip select
    output logic sdiPin,       // Serial data to device
    input wire logic sdoLine   // Pulled-up serial out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle levels from time zero
    initial begin
        sclkPin = 1'b0;  // Mode 0,0 idles low
        csPin_n = 1'b1;
        sdiPin = 1'b0;
    end
    // Whole 24-bit frame, sampling the echo on rising edges
    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
        @(posedge mclk);
        csPin_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 23; i >= 0; i--) begin  // Exactly 24 bits per frame
            sdiPin <= tx[i];  // Most significant bit first
            repeat (4) @(posedge mclk);
            sclkPin <= 1'b1;  // Device samples here
            rx[i] = sdoLine;
            repeat (4) @(posedge mclk);
            sclkPin <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        csPin_n <= 1'b1;
        sdiPin <= ~tx[0];  // Released line shows no stale bit
        repeat (12) @(posedge mclk);
    endtask : xfer
    // Select pulse with no clock activity
    task automatic bare();
        @(posedge mclk);
        csPin_n <= 1'b0;
        repeat (4) @(posedge mclk);
        csPin_n <= 1'b1;
        repeat (12) @(posedge mclk);
    endtask : bare
endmodule : spi_host_model

/* verif/dual_wiper_serial_command_unit_bench.sv */
// Command-level bench for the two-channel wiper core
module dual_wiper_serial_command_unit_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import wiper_cmd_pkg::*;
    localparam int STORE_W = 50;  // Short store time
    logic mclk = 1'b0;  // System clock
    logic resetn = 1'b0;  // Reset, active low
    logic preset_strobe_n = 1'b1;  // Preset idle
    logic writeProtect_n = 1'b1;  // Protection off
    logic sclkPin, csPin_n, sdiPin, sdoOut, sdoOe, readyOut, readyOe, readyPrev;
    logic [9:0] wiperOne, wiperTwo;  // Wiper outputs
    logic [23:0] rxWord;  // Echo of last frame
    int bad_count = 0;
    int checked = 0;
    int readyCnt = 0;  // Ready pulses seen
    int rc;
    wire sdoLine = sdoOe ? sdoOut : 1'b1;  // Pull-up on open drain
    always #12.5 mclk = ~mclk;
    wiper_command_unit #(.STORE_WAIT(STORE_W)) i_dut (.mclk(mclk), .resetn(resetn),
        .sclkPin(sclkPin), .csPin_n(csPin_n), .sdiPin(sdiPin), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .preset_strobe_n(preset_strobe_n), .writeProtect_n(writeProtect_n),
        .readyOut(readyOut), .readyOe(readyOe), .wiperOne(wiperOne), .wiperTwo(wiperTwo));
    spi_host_model i_host (.mclk(mclk), .sclkPin(sclkPin), .csPin_n(csPin_n),
        .sdiPin(sdiPin), .sdoLine(sdoLine));
    // Count rising edges of the ready pulse
    always @(posedge mclk) begin
        readyPrev <= readyOe;
        if (readyOe === 1'b1 && readyPrev !== 1'b1) begin
            readyCnt <= readyCnt + 1;
        end
    end
    task automatic report(input string what, input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s %h, wanted %h", $time, what, got, exp);
        end
    endtask : report
    task automatic chkWord(input logic [23:0] got, input logic [23:0] exp);
        report("word", got, exp);
    endtask : chkWord
    task automatic chkWiper(input logic [9:0] got, input logic [9:0] exp);
        report("wiper", {14'h0000, got}, {14'h0000, exp});
    endtask : chkWiper
    task automatic chkFlag(input logic got, input logic exp);
        report("flag", {23'h00_0000, got}, {23'h00_0000, exp});
    endtask : chkFlag
    task automatic run(input logic [23:0] w);
        i_host.xfer(w, rxWord);
    endtask : run
    // Bounded wait for a ready pulse after a count snapshot
    task automatic waitReady(input int base);
        int n;
        n = 0;
        while (readyCnt == base && n < STORE_W + 200) begin
            @(posedge mclk);
            n++;
        end
        chkFlag(readyCnt != base, 1'b1);
    endtask : waitReady
    task automatic endTest(input string name);
        $display("test %s done, mismatches so far %0d", name, bad_count);
    endtask : endTest
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Watchdog well beyond the expected run
    initial begin
        #1_000_000;
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        chkWiper(wiperOne, WIPER_MID);
        chkWiper(wiperTwo, WIPER_MID);
        run(24'hB0_0100);
        run(24'hB1_03FF);
        chkWiper(wiperOne, 10'h100);
        chkWiper(wiperTwo, 10'h3FF);
        chkWord(rxWord, 24'hB0_0100);
        chkFlag(sdoOe, 1'b0);
        endTest("write");
        run(24'hE1_0000);
        chkWiper(wiperTwo, 10'h3FF);
        run(24'h60_0000);
        chkWiper(wiperOne, 10'h0FF);
        run(24'hF0_0000);
        chkWiper(wiperOne, 10'h100);
        run(24'h70_0000);
        chkWiper(wiperTwo, 10'h3FE);
        run(24'hB0_0001);
        run(24'h40_0000);
        run(24'h40_0000);
        chkWiper(wiperOne, 10'h000);
        run(24'hB0_0300);
        run(24'hC0_0000);
        chkWiper(wiperOne, 10'h3FF);
        run(24'h50_0000);
        chkWiper(wiperTwo, 10'h1FF);
        run(24'hD0_0000);
        chkWiper(wiperOne, 10'h3FE);
        endTest("step");
        run(24'hB0_0155);
        rc = readyCnt;
        run(24'h20_0000);
        waitReady(rc);
        run(24'hB0_0000);
        run(24'h10_0000);
        chkWiper(wiperOne, 10'h155);
        run(24'hB1_0000);
        rc = readyCnt;
        run(24'h80_0000);
        waitReady(rc);
        chkWiper(wiperTwo, WIPER_MID);
        endTest("store");
        rc = readyCnt;
        run(24'h35_ABCD);
        waitReady(rc);
        run(24'h95_0000);
        run(24'h00_0000);
        chkWord(rxWord, 24'h95_ABCD);
        run(24'hA0_0000);
        run(24'h00_0000);
        chkWord(rxWord, 24'hA0_0155);
        chkWiper(wiperOne, 10'h155);
        run(24'hE0_0000);
        i_host.bare();
        chkWiper(wiperOne, 10'h157);
        rc = readyCnt;
        run(24'h3F_1234);
        chkFlag(readyCnt != rc, 1'b0);
        endTest("readback");
        run(24'hB0_0022);
        writeProtect_n <= 1'b0;
        run(24'hB0_0011);
        chkWiper(wiperOne, 10'h022);
        run(24'h10_0000);
        chkWiper(wiperOne, 10'h155);
        writeProtect_n <= 1'b1;
        preset_strobe_n <= 1'b0;
        repeat (10) @(posedge mclk);
        chkWiper(wiperOne, WIPER_MID);
        rc = readyCnt;
        preset_strobe_n <= 1'b1;
        waitReady(rc);
        chkWiper(wiperOne, 10'h155);
        endTest("protect");
        conclude();
    end
endmodule : dual_wiper_serial_command_unit_bench
